// [shared/lbac_pkg.sv]
package lbac_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] PHYS_CTL_OFF = 8'h00; // physical cpu interface control
  localparam logic [7:0] VIRT_CTL_OFF = 8'h04; // virtual cpu interface control
  localparam logic [7:0] DIST_CTL_OFF = 8'h08; // distributor control copy
  localparam logic [7:0] SRA_OFF = 8'h0c; // system register access enables
  localparam logic [7:0] TOP_CTL_OFF = 8'h10; // top level cpu interface control
  localparam logic [7:0] VPE_CNT_OFF = 8'h14; // legacy vm processing element count
  localparam logic [7:0] STATUS_OFF = 8'h18; // read only status

  // field widths in the low bits of each word
  localparam int PHYS_CTL_W = 8;
  localparam int VIRT_CTL_W = 3;
  localparam int DIST_CTL_W = 3;
  localparam int SRA_W = 4;
  localparam int VPE_W = 4;
  localparam int STATUS_W = 6;

  // documented ceiling on legacy vm processing elements
  localparam int VPE_MAX_DEF = 32'h0000_0008;

  // special identifiers
  localparam int ID_SECURE_G0 = 32'h0000_03fc; // 1020
  localparam int ID_NS_G1 = 32'h0000_03fd; // 1021
  localparam int ID_LEGACY_G1 = 32'h0000_03fe; // 1022
  localparam int ID_SPURIOUS = 32'h0000_03ff; // 1023
  localparam int ID_W_MIN = 32'h0000_000a; // narrowest id that holds 1023

  // physical control, bit 0 at the bottom
  typedef struct packed {
    logic normal_bypass_off_g1; // bit 7
    logic normal_bypass_off_g0; // bit 6
    logic fast_bypass_off_g1; // bit 5
    logic fast_bypass_off_g0; // bit 4
    logic group0_fast_route_on; // bit 3
    logic shared_ack_control; // bit 2, always zero here
    logic group1_signal_on; // bit 1
    logic group0_signal_on; // bit 0
  } lbac_phys_ctl_t;

  typedef struct packed {
    logic shared_ack_control; // bit 2
    logic group1_signal_on; // bit 1
    logic group0_signal_on; // bit 0
  } lbac_virt_ctl_t;

  typedef struct packed {
    logic single_security_state; // bit 2
    logic secure_affinity_routing_on; // bit 1
    logic nonsecure_affinity_routing_on; // bit 0
  } lbac_dist_ctl_t;

  typedef struct packed {
    logic access_top; // bit 3, highest level
    logic access_hyp; // bit 2
    logic access_low_ns; // bit 1
    logic access_low_s; // bit 0
  } lbac_sysreg_access_t;

  // highest pending interrupt description
  typedef struct packed {
    logic valid; // something pending
    logic sec_g0; // secure group 0
    logic ns_g1; // non-secure group 1
    logic grp1; // any group 1
  } lbac_pending_t;

  // values after reset
  localparam lbac_phys_ctl_t PHYS_CTL_RST = 8'h00;
  localparam lbac_virt_ctl_t VIRT_CTL_RST = 3'h0;
  localparam lbac_dist_ctl_t DIST_CTL_RST = 3'h0;
  localparam lbac_sysreg_access_t SRA_RST = 4'h0;
  localparam logic [3:0] VPE_CNT_RST = 4'h1;
  localparam logic TOP_CTL_RST = 1'h0;

endpackage

// [verilog/lbac_bypass_sel.sv]
`timescale 1ns/1ps
module lbac_bypass_sel
  import lbac_pkg::*;
(
  input wire lbac_phys_ctl_t ctl, // physical control bits
  input wire logic asym, // asymmetric configuration
  input wire logic own_fast, // controller fast request
  input wire logic own_normal, // controller normal request
  input wire logic fast_src, // external fast bypass
  input wire logic normal_src, // external normal bypass
  output logic next_fast, // selected fast level
  output logic next_normal // selected normal level
);

  wire route = ctl.group0_fast_route_on; // group 0 goes out as fast
  wire g0 = ctl.group0_signal_on; // group 0 enable
  wire g1 = ctl.group1_signal_on; // group 1 enable
  // both disables needed to silence the unrouted bypass
  wire fast_both_off = ctl.fast_bypass_off_g0 & ctl.fast_bypass_off_g1;
  wire normal_both_off = ctl.normal_bypass_off_g0 & ctl.normal_bypass_off_g1;
  wire fast_unrouted = fast_both_off ? 1'b0 : fast_src;
  // routed fast, bypass while group 0 off
  wire fast_routed = g0 ? own_fast : (ctl.fast_bypass_off_g0 ? 1'b0 : fast_src);
  // fast-class requests fall onto normal when asymmetric and unrouted
  wire own_normal_eff = own_normal | (asym & own_fast);
  // unrouted normal, bypass only with both groups off
  wire normal_unrouted = (g0 | g1) ? own_normal_eff : (normal_both_off ? 1'b0 : normal_src);
  // routed normal, bypass while group 1 off
  wire normal_routed = g1 ? own_normal : (ctl.normal_bypass_off_g1 ? 1'b0 : normal_src);

  assign next_fast = route ? fast_routed : fast_unrouted;
  assign next_normal = route ? normal_routed : normal_unrouted;

endmodule

// [verilog/lbac_id_resp.sv]
`timescale 1ns/1ps
module lbac_id_resp
  import lbac_pkg::*;
#(
  parameter int ID_W = 10 // identifier width
)
(
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic req, // one cycle id query
  input wire logic virt, // query on the virtual interface
  input wire logic group, // queried group, 0 or 1
  input wire logic route_mod, // routing modifier
  input wire logic shared_ack, // virtual shared acknowledge
  input wire lbac_pending_t hp, // highest pending description
  input wire logic [ID_W-1:0] intid, // highest pending id
  output logic id_valid, // answer strobe
  output logic [ID_W-1:0] id_data // answered id
);

  localparam logic [ID_W-1:0] SEC_G0 = ID_W'(ID_SECURE_G0);
  localparam logic [ID_W-1:0] NS_G1 = ID_W'(ID_NS_G1);
  localparam logic [ID_W-1:0] LEG_G1 = ID_W'(ID_LEGACY_G1);
  localparam logic [ID_W-1:0] SPUR = ID_W'(ID_SPURIOUS);

  // modifier only steers the physical system register path
  wire mod_on = route_mod & ~virt;
  // group 0 query of group 1 on virtual side without shared ack
  wire legacy_g1 = virt & hp.grp1 & ~group & ~shared_ack;
  wire [ID_W-1:0] next_id =
    !hp.valid ? SPUR :
    (mod_on & hp.sec_g0) ? SEC_G0 :
    (mod_on & hp.ns_g1) ? NS_G1 :
    legacy_g1 ? LEG_G1 : intid;

  // answer registered, one cycle after the query
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id_valid <= 1'b0;
      id_data <= '0;
    end else begin
      id_valid <= req;
      id_data <= req ? next_id : id_data;
    end
  end

  sec_g0_id_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && route_mod && !virt && hp.valid && hp.sec_g0) |=> (id_valid && id_data == SEC_G0))
    else $error("secure group 0 id not 1020");
  ns_g1_id_a: assert property (@(posedge clk) disable iff (!rst_n)
    (req && route_mod && !virt && hp.valid && !hp.sec_g0 && hp.ns_g1) |=> (id_data == NS_G1))
    else $error("non-secure group 1 id not 1021");

endmodule

// [verilog/lbac_top.sv]
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
module lbac_top
  import lbac_pkg::*;
#(
  parameter bit LEGACY_OK = 1'b1, // legacy operation implemented
  parameter int VPE_MAX = VPE_MAX_DEF, // legacy vm element ceiling
  parameter int ID_W = 10 // identifier width
)
(
  input wire logic CLK, // core clock, 20 MHz
  input wire logic RST_N, // async reset, active low
  input wire logic [7:0] ADDR, // register byte address
  input wire logic [31:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [31:0] RDATA, // read data, cycle after rd
  input wire logic OWN_FAST, // controller own fast request
  input wire logic OWN_NORMAL, // controller own normal request
  input wire logic FAST_BYPASS_INPUT, // external fast bypass source
  input wire logic NORMAL_BYPASS_INPUT, // external normal bypass source
  input wire logic VIRT_G0_PEND, // virtual group 0 pending
  input wire logic VIRT_G1_PEND, // virtual group 1 pending
  input wire logic ID_REQ, // id query strobe
  input wire logic ID_VIRT, // query on virtual interface
  input wire logic ID_GROUP, // queried group
  input wire lbac_pending_t HP_INFO, // highest pending description
  input wire logic [ID_W-1:0] HP_INTID, // highest pending id
  output logic FAST_OUT, // fast exception to core
  output logic NORMAL_OUT, // normal exception to core
  output logic VFAST_OUT, // virtual group 0 signal
  output logic VNORMAL_OUT, // virtual group 1 signal
  output logic ASYM_OUT, // asymmetric configuration seen
  output logic ID_VALID, // id answer strobe
  output logic [ID_W-1:0] ID_DATA // id answer
);

  // refuse shapes the logic cannot serve, at elaboration
  if (VPE_MAX < 1 || VPE_MAX > VPE_MAX_DEF) begin : g_vpe_bad
    $error("VPE_MAX must lie in 1..8");
  end
  // narrower ids cannot carry the special values
  if (ID_W < ID_W_MIN || ID_W > 24) begin : g_id_bad
    $error("ID_W must lie in 10..24");
  end

  // address compare used by every decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  // stored control state
  lbac_phys_ctl_t phys_ctl; // physical cpu interface control
  lbac_virt_ctl_t virt_ctl; // virtual cpu interface control
  lbac_dist_ctl_t dist_ctl; // distributor control copy
  lbac_sysreg_access_t sra; // system register access enables
  logic route_mod; // routing modifier
  logic [VPE_W-1:0] vpe_cnt; // elements in legacy vm

  // per-register write decodes
  wire wr_phys = WR & hit(ADDR, PHYS_CTL_OFF); // physical control write
  wire wr_virt = WR & hit(ADDR, VIRT_CTL_OFF); // virtual control write
  wire wr_dist = WR & hit(ADDR, DIST_CTL_OFF); // distributor copy write
  wire wr_sra = WR & hit(ADDR, SRA_OFF) & LEGACY_OK; // access enable write
  wire wr_top = WR & hit(ADDR, TOP_CTL_OFF); // top control write
  // counts above the ceiling are dropped
  wire vpe_ok = 32'(WDATA[VPE_W-1:0]) <= VPE_MAX; // count within ceiling
  wire wr_vpe = WR & hit(ADDR, VPE_CNT_OFF) & vpe_ok; // accepted count write

  // physical shared ack is stored as zero
  wire lbac_phys_ctl_t next_phys = {WDATA[7:3], 1'b0, WDATA[1:0]};
  // routing bits: writes to them vanish without legacy support
  wire next_ns_route = LEGACY_OK ? WDATA[0] : 1'b1;
  wire next_s_route = LEGACY_OK ? WDATA[1] : 1'b1;
  wire lbac_dist_ctl_t next_dist = {WDATA[2], next_s_route, next_ns_route};

  wire lbac_sysreg_access_t sra_eff = LEGACY_OK ? sra : 4'hf;
  wire lbac_dist_ctl_t dist_eff = dist_ctl;

  // register file writes; routing resets to one without legacy
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phys_ctl <= PHYS_CTL_RST;
      virt_ctl <= VIRT_CTL_RST;
      dist_ctl <= LEGACY_OK ? DIST_CTL_RST : 3'h3;
      sra <= SRA_RST;
      route_mod <= TOP_CTL_RST;
      vpe_cnt <= VPE_CNT_RST;
    end else begin
      if (wr_phys) phys_ctl <= next_phys;
      if (wr_virt) virt_ctl <= WDATA[VIRT_CTL_W-1:0];
      if (wr_dist) dist_ctl <= next_dist;
      if (wr_sra) sra <= WDATA[SRA_W-1:0];
      if (wr_top) route_mod <= WDATA[0];
      if (wr_vpe) vpe_cnt <= WDATA[VPE_W-1:0];
    end
  end

  wire asym = dist_eff.nonsecure_affinity_routing_on & ~dist_eff.secure_affinity_routing_on &
    sra_eff.access_top & ~sra_eff.access_low_s;

  // bypass and own-output selection
  logic next_fast; // selected fast level
  logic next_normal; // selected normal level
  lbac_bypass_sel u_sel (
    .ctl(phys_ctl),
    .asym(asym),
    .own_fast(OWN_FAST),
    .own_normal(OWN_NORMAL),
    .fast_src(FAST_BYPASS_INPUT),
    .normal_src(NORMAL_BYPASS_INPUT),
    .next_fast(next_fast),
    .next_normal(next_normal)
  );

  wire next_vfast = virt_ctl.group0_signal_on & VIRT_G0_PEND;
  wire next_vnormal = virt_ctl.group1_signal_on & VIRT_G1_PEND;

  // status word shows live block state
  wire [STATUS_W-1:0] status = {LEGACY_OK, VNORMAL_OUT, VFAST_OUT, NORMAL_OUT, FAST_OUT, ASYM_OUT};

  // read mux; unmapped addresses answer zero
  wire [31:0] next_rdata =
    hit(ADDR, PHYS_CTL_OFF) ? {24'h0, phys_ctl} :
    hit(ADDR, VIRT_CTL_OFF) ? {29'h0, virt_ctl} :
    hit(ADDR, DIST_CTL_OFF) ? {29'h0, dist_eff} :
    hit(ADDR, SRA_OFF) ? {28'h0, sra_eff} :
    hit(ADDR, TOP_CTL_OFF) ? {31'h0, route_mod} :
    hit(ADDR, VPE_CNT_OFF) ? {28'h0, vpe_cnt} :
    hit(ADDR, STATUS_OFF) ? {26'h0, status} : 32'h0;

  // outputs registered, change shows next cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      FAST_OUT <= 1'b0;
      NORMAL_OUT <= 1'b0;
      VFAST_OUT <= 1'b0;
      VNORMAL_OUT <= 1'b0;
      ASYM_OUT <= 1'b0;
    end else begin
      FAST_OUT <= next_fast;
      NORMAL_OUT <= next_normal;
      VFAST_OUT <= next_vfast;
      VNORMAL_OUT <= next_vnormal;
      ASYM_OUT <= asym;
    end
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD ? next_rdata : 32'h0;
    end
  end

  // special id answers; shared ack comes from the virtual side only
  lbac_id_resp #(
    .ID_W(ID_W)
  ) u_id (
    .clk(CLK),
    .rst_n(RST_N),
    .req(ID_REQ),
    .virt(ID_VIRT),
    .group(ID_GROUP),
    .route_mod(route_mod),
    .shared_ack(virt_ctl.shared_ack_control),
    .hp(HP_INFO),
    .intid(HP_INTID),
    .id_valid(ID_VALID),
    .id_data(ID_DATA)
  );

  legacy_ro_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!LEGACY_OK && RD && ADDR == SRA_OFF) |=> RDATA[3:0] == 4'hf)
    else $error("access enables not read as one");

  route_ro_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!LEGACY_OK && RD && ADDR == DIST_CTL_OFF) |=> RDATA[1:0] == 2'h3)
    else $error("routing enables not read as one");

  fast_unrouted_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!phys_ctl.group0_fast_route_on) |=>
      FAST_OUT == (($past(phys_ctl.fast_bypass_off_g0) && $past(phys_ctl.fast_bypass_off_g1)) ?
        1'b0 : $past(FAST_BYPASS_INPUT)))
    else $error("unrouted fast output wrong");

  fast_routed_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (phys_ctl.group0_fast_route_on && phys_ctl.group0_signal_on) |=> FAST_OUT == $past(OWN_FAST))
    else $error("routed fast output not own");

  fast_bypass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (phys_ctl.group0_fast_route_on && !phys_ctl.group0_signal_on && !phys_ctl.fast_bypass_off_g0)
      |=> FAST_OUT == $past(FAST_BYPASS_INPUT))
    else $error("routed fast bypass wrong");

  normal_unrouted_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!phys_ctl.group0_fast_route_on && !phys_ctl.group0_signal_on && !phys_ctl.group1_signal_on &&
      phys_ctl.normal_bypass_off_g0 && phys_ctl.normal_bypass_off_g1) |=> !NORMAL_OUT)
    else $error("unrouted normal not deasserted");

  normal_routed_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (phys_ctl.group0_fast_route_on && !phys_ctl.group1_signal_on) |=>
      NORMAL_OUT == ($past(phys_ctl.normal_bypass_off_g1) ? 1'b0 : $past(NORMAL_BYPASS_INPUT)))
    else $error("routed normal bypass wrong");

  asym_flag_a: assert property (@(posedge CLK) disable iff (!RST_N)
    ##1 ASYM_OUT == $past(dist_eff.nonsecure_affinity_routing_on && !dist_eff.secure_affinity_routing_on &&
      sra_eff.access_top && !sra_eff.access_low_s))
    else $error("asymmetric flag wrong");

  asym_reroute_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (asym && !phys_ctl.group0_fast_route_on && phys_ctl.group0_signal_on && OWN_FAST) |=> NORMAL_OUT)
    else $error("asymmetric fast request not on normal");

  vpe_limit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    32'(vpe_cnt) <= VPE_MAX)
    else $error("element count above ceiling");

  virt_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!virt_ctl.group0_signal_on || !virt_ctl.group1_signal_on) |=>
      ($past(virt_ctl.group0_signal_on) || !VFAST_OUT) && ($past(virt_ctl.group1_signal_on) || !VNORMAL_OUT))
    else $error("virtual signal passed while disabled");

  phys_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (RD && ADDR == PHYS_CTL_OFF) |=> !RDATA[2])
    else $error("physical shared ack not zero");

  read_once_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !RD |=> RDATA == 32'h0)
    else $error("read data outside read cycle");

  virt_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (virt_ctl.group0_signal_on && VIRT_G0_PEND) |=> VFAST_OUT)
    else $error("virtual group 0 not signalled");

  vnorm_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (virt_ctl.group1_signal_on && VIRT_G1_PEND) |=> VNORMAL_OUT)
    else $error("virtual group 1 not signalled");

  vpe_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == VPE_CNT_OFF && 32'(WDATA[VPE_W-1:0]) > VPE_MAX) |=> $stable(vpe_cnt))
    else $error("oversize element count taken");

  virt_ack_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (WR && ADDR == VIRT_CTL_OFF) |=> virt_ctl.shared_ack_control == $past(WDATA[2]))
    else $error("virtual shared ack not stored");

  normal_own_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (phys_ctl.group0_fast_route_on && phys_ctl.group1_signal_on) |=> NORMAL_OUT == $past(OWN_NORMAL))
    else $error("routed normal output not own");

  normal_group_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (!phys_ctl.group0_fast_route_on && (phys_ctl.group0_signal_on || phys_ctl.group1_signal_on) && !asym)
      |=> NORMAL_OUT == $past(OWN_NORMAL))
    else $error("unrouted normal output not own");

  fast_off_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (phys_ctl.group0_fast_route_on && !phys_ctl.group0_signal_on && phys_ctl.fast_bypass_off_g0) |=> !FAST_OUT)
    else $error("routed fast bypass not deasserted");

  asym_clear_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !dist_eff.nonsecure_affinity_routing_on |=> !ASYM_OUT)
    else $error("asymmetric flag without routing");

endmodule

// [test/lbac_core_model.sv]
`timescale 1ns/1ps
module lbac_core_model (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic fast, // fast exception level
  input wire logic normal, // normal exception level
  output logic [7:0] fast_taken, // fast exceptions taken
  output logic [7:0] normal_taken // normal exceptions taken
);
  logic fast_d; // last fast level
  logic normal_d; // last normal level
  // core takes one exception per rising level; nothing latched, so a
  // one-cycle glitch still counts, just as on a real core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_d <= 1'b0;
      normal_d <= 1'b0;
      fast_taken <= 8'h00;
      normal_taken <= 8'h00;
    end else begin
      fast_d <= fast;
      normal_d <= normal;
      if (fast && !fast_d) begin
        fast_taken <= fast_taken + 8'h01;
      end
      if (normal && !normal_d) begin
        normal_taken <= normal_taken + 8'h01;
      end
    end
  end
endmodule

// [test/lbac_top_tb.sv]
`timescale 1ns/1ps
module lbac_top_tb
  import lbac_pkg::*;
;
  logic clk = 1'b0; // core clock
  logic rst_n = 1'b0; // reset, active low
  logic [7:0] addr; // bus address
  logic [31:0] wdata; // bus write data
  logic wr, rd; // bus strobes
  logic [31:0] rdata, rdata2; // read data, both instances
  logic own_fast, own_normal, fast_src, normal_src; // exception sources
  logic vg0, vg1, id_req, id_virt, id_group; // virtual and id inputs
  lbac_pending_t hp; // highest pending description
  logic [9:0] intid; // highest pending id
  logic fast_out, normal_out, vfast, vnormal, asym, id_valid; // outputs
  logic [9:0] id_data; // id answer
  logic [7:0] fast_taken, normal_taken; // core model counts
  logic [31:0] got, got2; // last read values
  logic [13:0] rows [14]; // ctl, own/src inputs, expected fast/normal
  int fail_count, n_tests, i;
  int cyc = 0; // cycles since start, hang guard only

  // main instance, legacy implemented
  lbac_top lbac_top_inst (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .OWN_FAST(own_fast), .OWN_NORMAL(own_normal), .FAST_BYPASS_INPUT(fast_src),
    .NORMAL_BYPASS_INPUT(normal_src), .VIRT_G0_PEND(vg0), .VIRT_G1_PEND(vg1), .ID_REQ(id_req),
    .ID_VIRT(id_virt), .ID_GROUP(id_group), .HP_INFO(hp), .HP_INTID(intid), .FAST_OUT(fast_out),
    .NORMAL_OUT(normal_out), .VFAST_OUT(vfast), .VNORMAL_OUT(vnormal), .ASYM_OUT(asym),
    .ID_VALID(id_valid), .ID_DATA(id_data));
  // second instance without legacy support, only its read data watched
  lbac_top #(.LEGACY_OK(1'b0)) lbac_top_inst2 (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata2), .OWN_FAST(own_fast), .OWN_NORMAL(own_normal),
    .FAST_BYPASS_INPUT(fast_src), .NORMAL_BYPASS_INPUT(normal_src), .VIRT_G0_PEND(vg0),
    .VIRT_G1_PEND(vg1), .ID_REQ(id_req), .ID_VIRT(id_virt), .ID_GROUP(id_group), .HP_INFO(hp),
    .HP_INTID(intid), .FAST_OUT(), .NORMAL_OUT(), .VFAST_OUT(), .VNORMAL_OUT(), .ASYM_OUT(),
    .ID_VALID(), .ID_DATA());
  // core on the far side of the exception outputs
  lbac_core_model lbac_core_model_inst (.clk(clk), .rst_n(rst_n), .fast(fast_out),
    .normal(normal_out), .fast_taken(fast_taken), .normal_taken(normal_taken));

  // 20 MHz clock
  always #25 clk = ~clk;

  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (exp !== seen) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read strobe, data caught in the following cycle only
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
    got2 = rdata2;
  endtask
  // let a register write reach the outputs
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  // id query, answer strobe in the next cycle
  task automatic id_q(input logic v, input logic g, input logic [9:0] exp);
    @(posedge clk);
    id_req <= 1'b1;
    id_virt <= v;
    id_group <= g;
    @(posedge clk);
    id_req <= 1'b0;
    #1;
    chk("id_valid", 32'h1, {31'h0, id_valid});
    chk("id_data", {22'h0, exp}, {22'h0, id_data});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    {addr, wdata, wr, rd, own_fast, own_normal, fast_src, normal_src} = '0;
    {vg0, vg1, id_req, id_virt, id_group, fail_count, n_tests} = '0;
    hp = 4'h0;
    intid = 10'h02a;
    rows = '{{8'h00, 4'he, 2'h2}, {8'h30, 4'h3, 2'h1}, {8'h50, 4'h3, 2'h3}, {8'hc0, 4'h1, 2'h0},
      {8'h01, 4'h3, 2'h2}, {8'h08, 4'h3, 2'h3}, {8'h18, 4'h3, 2'h1}, {8'h28, 4'h2, 2'h2},
      {8'h09, 4'h3, 2'h1}, {8'h0a, 4'h4, 2'h1}, {8'h88, 4'h3, 2'h2}, {8'h48, 4'h1, 2'h1},
      {8'h09, 4'h8, 2'h2}, {8'h02, 4'h4, 2'h1}};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // bypass selection table, dist control still zero so not asymmetric
    for (i = 0; i < 14; i++) begin
      {own_fast, own_normal, fast_src, normal_src} <= rows[i][5:2];
      wr_reg(PHYS_CTL_OFF, {24'h0, rows[i][13:6]});
      settle();
      chk("fast_out", {31'h0, rows[i][1]}, {31'h0, fast_out});
      chk("normal_out", {31'h0, rows[i][0]}, {31'h0, normal_out});
    end
    {own_fast, own_normal, fast_src, normal_src} <= 4'h0;
    wr_reg(PHYS_CTL_OFF, 32'h0);
    settle();
    rd_reg(STATUS_OFF);
    chk("status", 32'h20, got);
    rd_reg(SRA_OFF);
    chk("access enables", 32'h0, got);
    chk("access enables no legacy", 32'hf, got2);
    wr_reg(SRA_OFF, 32'h0);
    wr_reg(DIST_CTL_OFF, 32'h0);
    rd_reg(SRA_OFF);
    chk("access enables no legacy", 32'hf, got2);
    rd_reg(DIST_CTL_OFF);
    chk("dist routing no legacy", 32'h3, got2);
    // no lockdown count offered; a stray write to a spare word vanishes
    wr_reg(8'h1c, 32'hf);
    rd_reg(8'h1c);
    chk("unmapped", 32'h0, got);
    // element count ceiling: too large is dropped, eight kept
    rd_reg(VPE_CNT_OFF);
    chk("vpe count", 32'h1, got);
    wr_reg(VPE_CNT_OFF, 32'h9);
    rd_reg(VPE_CNT_OFF);
    chk("vpe count", 32'h1, got);
    wr_reg(VPE_CNT_OFF, 32'h8);
    rd_reg(VPE_CNT_OFF);
    chk("vpe count", 32'h8, got);
    // shared ack reads zero on physical, kept on virtual
    wr_reg(PHYS_CTL_OFF, 32'h4);
    rd_reg(PHYS_CTL_OFF);
    chk("phys shared ack", 32'h0, got);
    wr_reg(VIRT_CTL_OFF, 32'h7);
    rd_reg(VIRT_CTL_OFF);
    chk("virt ctl", 32'h7, got);
    // virtual group gates
    {vg0, vg1} <= 2'h3;
    wr_reg(VIRT_CTL_OFF, 32'h1);
    settle();
    chk("vfast", 32'h1, {31'h0, vfast});
    chk("vnormal", 32'h0, {31'h0, vnormal});
    wr_reg(VIRT_CTL_OFF, 32'h2);
    settle();
    chk("vfast", 32'h0, {31'h0, vfast});
    chk("vnormal", 32'h1, {31'h0, vnormal});
    // asymmetric: ns routing, top and hyp access, secure low access off
    own_fast <= 1'b1;
    wr_reg(PHYS_CTL_OFF, 32'h1);
    settle();
    chk("normal_out", 32'h0, {31'h0, normal_out});
    wr_reg(DIST_CTL_OFF, 32'h1);
    wr_reg(SRA_OFF, 32'hc);
    settle();
    chk("asym", 32'h1, {31'h0, asym});
    chk("normal_out", 32'h1, {31'h0, normal_out});
    wr_reg(SRA_OFF, 32'hd);
    settle();
    chk("asym", 32'h0, {31'h0, asym});
    wr_reg(SRA_OFF, 32'hc);
    wr_reg(DIST_CTL_OFF, 32'h3);
    settle();
    chk("asym", 32'h0, {31'h0, asym});
    // special identifiers with the routing modifier on, both groups, then with it off
    wr_reg(TOP_CTL_OFF, 32'h1);
    for (i = 0; i < 2; i++) begin
      hp <= 4'hc;
      id_q(1'b0, i[0], ID_SECURE_G0[9:0]);
      hp <= 4'hb;
      id_q(1'b0, i[0], ID_NS_G1[9:0]);
    end
    id_q(1'b1, 1'b0, ID_LEGACY_G1[9:0]);
    id_q(1'b1, 1'b1, 10'h02a);
    wr_reg(VIRT_CTL_OFF, 32'h6);
    id_q(1'b1, 1'b0, 10'h02a);
    wr_reg(TOP_CTL_OFF, 32'h0);
    hp <= 4'hc;
    id_q(1'b0, 1'b0, 10'h02a);
    hp <= 4'h0;
    id_q(1'b0, 1'b0, ID_SPURIOUS[9:0]);
    chk("core fast taken", 32'h1, {31'h0, fast_taken != 8'h00});
    chk("core normal taken", 32'h1, {31'h0, normal_taken != 8'h00});
    // mid-run reset: outputs clear at once, registers back to reset values
    @(posedge clk);
    {own_fast, rst_n} <= 2'h0;
    settle();
    chk("vnormal rst", 32'h0, {31'h0, vnormal});
    @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(VPE_CNT_OFF);
    chk("vpe count rst", 32'h1, got);
    rd_reg(VIRT_CTL_OFF);
    chk("virt ctl rst", 32'h0, got);
    complete_run();
  end
endmodule
